// ==== include/pirqs_pkg.sv ====
// Purpose: shared constants for the peripheral interrupt source block
// Assumes: 32-bit axi4-lite register access, 8-bit control registers in low bits
// Notes:   offsets are byte addresses of aligned words
package pirqs_pkg;
    localparam logic [7:0] ADDR_MAIN_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_SECOND_CTRL = 8'h04;
    localparam logic [7:0] ADDR_THIRD_CTRL  = 8'h08;
    localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h0c;
    localparam logic [7:0] ADDR_EVT_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_EVT_CLEAR   = 8'h14;
    localparam logic [7:0] ADDR_EVT_ENABLE  = 8'h18;
    localparam logic [7:0] ADDR_CORE_STATUS = 8'h1c;

    // main control fields
    localparam int MAIN_GLOBAL_EN   = 7;
    localparam int MAIN_TMR_EN      = 5;
    localparam int MAIN_EXT0_EN     = 4;
    localparam int MAIN_PORT_EN     = 3;
    localparam int MAIN_TMR_FLAG    = 2;
    localparam int MAIN_EXT0_FLAG   = 1;
    localparam int MAIN_PORT_FLAG   = 0;
    // second control fields
    localparam int SEC_EDGE0        = 6;
    localparam int SEC_EDGE1        = 5;
    localparam int SEC_EDGE2        = 4;
    localparam int SEC_TMR_PRIO     = 2;
    localparam int SEC_PORT_PRIO    = 0;
    // third control fields
    localparam int THIRD_TWO_PRIO   = 7;
    localparam int THIRD_ONE_PRIO   = 6;
    localparam int THIRD_TWO_EN     = 4;
    localparam int THIRD_ONE_EN     = 3;
    localparam int THIRD_TWO_FLAG   = 1;
    localparam int THIRD_ONE_FLAG   = 0;
    // timer control fields
    localparam int TCTL_RUN         = 7;
    localparam int TCTL_EIGHT_BIT   = 6;

    localparam logic [7:0] MAIN_RESET   = 8'h00;
    localparam logic [7:0] SECOND_RESET = 8'h70;
    localparam logic [7:0] THIRD_RESET  = 8'hc0;
    localparam logic [7:0] TIMER_RESET  = 8'h40;
    localparam int         NUM_EVT      = 5;
    localparam logic [1:0] RESP_OKAY    = 2'b00;
    localparam logic [1:0] RESP_SLVERR  = 2'b10;
endpackage : pirqs_pkg

// ==== hw/pirqs_edge_detect.sv ====
// Purpose: synchronise one pin and report a selected-polarity edge
// Assumes: pin is asynchronous to aclk
// Notes:   one-cycle pulse out
`timescale 1ns/100ps
`default_nettype none
module pirqs_edge_detect (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    input  wire logic rising_sel,
    output logic      level,
    output logic      edge_pulse
);
    logic       meta_reg;
    logic       sync_reg;
    logic       last_reg;
    logic [2:0] prime_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg  <= 1'b0;
            sync_reg  <= 1'b0;
            last_reg  <= 1'b0;
            prime_reg <= 3'b000;
        end else begin
            meta_reg  <= pin;
            sync_reg  <= meta_reg;
            last_reg  <= sync_reg;
            prime_reg <= {prime_reg[1:0], 1'b1};
        end
    end

    assign level = sync_reg;
    // polarity from select
    // held off until the pipe is full: a pin idling high must not look like an edge after reset
    assign edge_pulse = prime_reg[2] & (rising_sel ? (sync_reg & ~last_reg) : (~sync_reg & last_reg));
endmodule : pirqs_edge_detect
`default_nettype wire

// ==== hw/pirqs_timer.sv ====
// Purpose: free-running timer with 8 or 16-bit overflow detection
// Assumes: counts one per clock while running
// Notes:   prescaler and high-byte buffering left out
`timescale 1ns/100ps
`default_nettype none
module pirqs_timer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        run,
    input  wire logic        eight_bit,
    input  wire logic        load,
    input  wire logic [15:0] load_value,
    output logic [15:0]      count,
    output logic             overflow
);
    logic [15:0] count_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 16'h0000;
        end else if (load) begin
            count_reg <= load_value;
        end else if (run) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    assign count = count_reg;
    // ffh to 00h in 8-bit mode
    // ffffh to 0000h in 16-bit mode
    assign overflow = run && !load &&
                      (eight_bit ? (count_reg[7:0] == 8'hff) : (count_reg == 16'hffff));
endmodule : pirqs_timer
`default_nettype wire

// ==== hw/pirqs_top.sv ====
// Purpose: five interrupt sources, priority split, wake and context save
// Assumes: core asserts irq_ack for one cycle when it takes the vector
// Notes:   registers reached over axi4-lite
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pirqs_top import pirqs_pkg::*; (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_irq_zero,
    input  wire logic        ext_irq_one,
    input  wire logic        ext_irq_two,
    input  wire logic [7:4]  port_b_pins,
    input  wire logic [7:4]  port_b_is_input,
    input  wire logic        core_sleeping,
    input  wire logic        irq_ack,
    input  wire logic [20:0] return_pc,
    input  wire logic [7:0]  working_register,
    input  wire logic [7:0]  status_register,
    input  wire logic [7:0]  bank_select_register,
    output logic             irq_high,
    output logic             irq_low,
    output logic             wake_up,
    output logic             stack_push,
    output logic [20:0]      stack_push_pc,
    output logic [7:0]       shadow_working,
    output logic [7:0]       shadow_status,
    output logic [7:0]       shadow_bank,
    output logic             evt_irq
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] wd,
                                              input logic [3:0] strb);
        merge_byte = strb[0] ? wd[7:0] : old_v;
    endfunction : merge_byte

    logic [7:0]  main_ctrl_reg;
    logic [7:0]  second_ctrl_reg;
    logic [7:0]  third_ctrl_reg;
    logic [7:0]  timer_ctrl_reg;
    logic [4:0]  evt_status_reg;
    logic [4:0]  evt_enable_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_do;
    logic        main_wr;
    logic        second_wr;
    logic        third_wr;
    logic        timer_wr;
    logic        clear_wr;
    logic        enable_wr;
    logic        wr_mapped;
    logic [7:0]  wr_addr;

    ////////////////////////////////////////////////////////////////////////////
    // axi write path: address and data may arrive in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign wr_do   = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_addr = aw_addr_reg;
    assign main_wr   = wr_do && wr_addr == ADDR_MAIN_CTRL;
    assign second_wr = wr_do && wr_addr == ADDR_SECOND_CTRL;
    assign third_wr  = wr_do && wr_addr == ADDR_THIRD_CTRL;
    assign timer_wr  = wr_do && wr_addr == ADDR_TIMER_CTRL;
    assign clear_wr  = wr_do && wr_addr == ADDR_EVT_CLEAR;
    assign enable_wr = wr_do && wr_addr == ADDR_EVT_ENABLE;
    assign wr_mapped = main_wr | second_wr | third_wr | timer_wr | clear_wr | enable_wr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sources
    logic        lvl0;
    logic        lvl1;
    logic        lvl2;
    logic        edge0;
    logic        edge1;
    logic        edge2;
    logic [15:0] timer_count;
    logic        timer_ovf;
    logic [7:4]  port_meta_reg;
    logic [7:4]  port_sync_reg;
    logic [7:4]  port_last_reg;
    logic [2:0]  port_prime_reg;
    logic        port_change;

    pirqs_edge_detect u_edge0 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin        (ext_irq_zero),
        .rising_sel (second_ctrl_reg[SEC_EDGE0]),
        .level      (lvl0),
        .edge_pulse (edge0)
    );
    pirqs_edge_detect u_edge1 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin        (ext_irq_one),
        .rising_sel (second_ctrl_reg[SEC_EDGE1]),
        .level      (lvl1),
        .edge_pulse (edge1)
    );
    pirqs_edge_detect u_edge2 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin        (ext_irq_two),
        .rising_sel (second_ctrl_reg[SEC_EDGE2]),
        .level      (lvl2),
        .edge_pulse (edge2)
    );
    pirqs_timer u_timer (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .run        (timer_ctrl_reg[TCTL_RUN]),
        .eight_bit  (timer_ctrl_reg[TCTL_EIGHT_BIT]),
        .load       (timer_wr),
        .load_value (w_data_reg[23:8]),
        .count      (timer_count),
        .overflow   (timer_ovf)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_meta_reg <= 4'h0;
            port_sync_reg <= 4'h0;
            port_last_reg <= 4'h0;
            port_prime_reg <= 3'b000;
        end else begin
            port_meta_reg <= port_b_pins;
            port_sync_reg <= port_meta_reg;
            port_last_reg <= port_sync_reg;
            port_prime_reg <= {port_prime_reg[1:0], 1'b1};
        end
    end
    // any input pin change; no false change while the pipe fills after reset
    assign port_change = port_prime_reg[2] & (|((port_sync_reg ^ port_last_reg) & port_b_is_input));

    ////////////////////////////////////////////////////////////////////////////
    // control registers; hardware set wins over a software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_ctrl_reg <= MAIN_RESET;
        end else begin
            if (main_wr) begin
                main_ctrl_reg <= merge_byte(main_ctrl_reg, w_data_reg, w_strb_reg);
            end
            if (edge0) begin
                main_ctrl_reg[MAIN_EXT0_FLAG] <= 1'b1;
            end
            if (timer_ovf) begin
                main_ctrl_reg[MAIN_TMR_FLAG] <= 1'b1;
            end
            if (port_change) begin
                main_ctrl_reg[MAIN_PORT_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            third_ctrl_reg <= THIRD_RESET;
        end else begin
            if (third_wr) begin
                third_ctrl_reg <= merge_byte(third_ctrl_reg, w_data_reg, w_strb_reg);
            end
            if (edge1) begin
                third_ctrl_reg[THIRD_ONE_FLAG] <= 1'b1;
            end
            if (edge2) begin
                third_ctrl_reg[THIRD_TWO_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            second_ctrl_reg <= SECOND_RESET;
            timer_ctrl_reg  <= TIMER_RESET;
        end else begin
            if (second_wr) begin
                second_ctrl_reg <= merge_byte(second_ctrl_reg, w_data_reg, w_strb_reg);
            end
            if (timer_wr) begin
                timer_ctrl_reg <= merge_byte(timer_ctrl_reg, w_data_reg, w_strb_reg);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // requests and priority
    logic req0;
    logic req1;
    logic req2;
    logic req_tmr;
    logic req_port;
    logic pend_high;
    logic pend_low;
    logic pend_any;
    logic ext_wake_reg;

    assign req0 = main_ctrl_reg[MAIN_EXT0_FLAG] & main_ctrl_reg[MAIN_EXT0_EN];
    assign req1 = third_ctrl_reg[THIRD_ONE_FLAG] & third_ctrl_reg[THIRD_ONE_EN];
    assign req2 = third_ctrl_reg[THIRD_TWO_FLAG] & third_ctrl_reg[THIRD_TWO_EN];
    assign req_tmr = main_ctrl_reg[MAIN_TMR_FLAG] & main_ctrl_reg[MAIN_TMR_EN];
    assign req_port = main_ctrl_reg[MAIN_PORT_FLAG] & main_ctrl_reg[MAIN_PORT_EN];

    // source zero always high; one, two, timer and port by their priority bits
    assign pend_high = req0
                     | (req1 & third_ctrl_reg[THIRD_ONE_PRIO])
                     | (req2 & third_ctrl_reg[THIRD_TWO_PRIO])
                     | (req_tmr & second_ctrl_reg[SEC_TMR_PRIO])
                     | (req_port & second_ctrl_reg[SEC_PORT_PRIO]);
    assign pend_low  = (req1 & ~third_ctrl_reg[THIRD_ONE_PRIO])
                     | (req2 & ~third_ctrl_reg[THIRD_TWO_PRIO])
                     | (req_tmr & ~second_ctrl_reg[SEC_TMR_PRIO])
                     | (req_port & ~second_ctrl_reg[SEC_PORT_PRIO]);
    assign pend_any  = pend_high | pend_low;

    assign irq_high = main_ctrl_reg[MAIN_GLOBAL_EN] & pend_high;
    assign irq_low  = main_ctrl_reg[MAIN_GLOBAL_EN] & pend_low;

    // enabled pin edge wakes sleeping core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_wake_reg <= 1'b0;
        end else begin
            ext_wake_reg <= core_sleeping && ((edge0 && main_ctrl_reg[MAIN_EXT0_EN])
                                           || (edge1 && third_ctrl_reg[THIRD_ONE_EN])
                                           || (edge2 && third_ctrl_reg[THIRD_TWO_EN]));
        end
    end
    assign wake_up = ext_wake_reg | (core_sleeping & pend_any);

    ////////////////////////////////////////////////////////////////////////////
    // context save on entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stack_push    <= 1'b0;
            stack_push_pc <= 21'h000000;
        end else begin
            stack_push <= irq_ack;
            if (irq_ack) begin
                stack_push_pc <= return_pc;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shadow_working <= 8'h00;
            shadow_status  <= 8'h00;
            shadow_bank    <= 8'h00;
        end else if (irq_ack) begin
            shadow_working <= working_register;
            shadow_status  <= status_register;
            shadow_bank    <= bank_select_register;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky event status for the bus interrupt line
    logic [4:0] evt_set;
    assign evt_set = {port_change, timer_ovf, edge2, edge1, edge0};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_status_reg <= 5'h00;
            evt_enable_reg <= 5'h00;
        end else begin
            // set wins over clear
            evt_status_reg <= (evt_status_reg & ~(clear_wr ? w_data_reg[4:0] : 5'h00)) | evt_set;
            if (enable_wr) begin
                evt_enable_reg <= w_data_reg[4:0];
            end
        end
    end
    assign evt_irq = |(evt_status_reg & evt_enable_reg);

    ////////////////////////////////////////////////////////////////////////////
    // axi read path; clear register reads as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                ADDR_MAIN_CTRL:   s_axi_rdata <= {24'h000000, main_ctrl_reg};
                ADDR_SECOND_CTRL: s_axi_rdata <= {24'h000000, second_ctrl_reg};
                ADDR_THIRD_CTRL:  s_axi_rdata <= {24'h000000, third_ctrl_reg};
                ADDR_TIMER_CTRL:  s_axi_rdata <= {8'h00, timer_count, timer_ctrl_reg};
                ADDR_EVT_STATUS:  s_axi_rdata <= {27'h0000000, evt_status_reg};
                ADDR_EVT_CLEAR:   s_axi_rdata <= 32'h0000_0000;
                ADDR_EVT_ENABLE:  s_axi_rdata <= {27'h0000000, evt_enable_reg};
                ADDR_CORE_STATUS: s_axi_rdata <= {25'h0000000, lvl2, lvl1, lvl0, port_sync_reg};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    ////////////////////////////////////////////////////////////////////////////
    a_edge_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        edge0 |=> main_ctrl_reg[MAIN_EXT0_FLAG]) else $error("pin zero edge did not set flag");
    a_flag_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        third_ctrl_reg[THIRD_ONE_FLAG] && !third_wr |=> third_ctrl_reg[THIRD_ONE_FLAG])
        else $error("pin one flag dropped without write");
    a_enable_gates: assert property (@(posedge aclk) disable iff (!aresetn)
        !third_ctrl_reg[THIRD_TWO_EN] |-> !req2) else $error("disabled source requested");
    a_zero_high: assert property (@(posedge aclk) disable iff (!aresetn)
        req0 && main_ctrl_reg[MAIN_GLOBAL_EN] |-> irq_high) else $error("source zero not high");
    a_global_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !main_ctrl_reg[MAIN_GLOBAL_EN] |-> !irq_high && !irq_low) else $error("vector without global");
    a_one_prio: assert property (@(posedge aclk) disable iff (!aresetn)
        req1 && !third_ctrl_reg[THIRD_ONE_PRIO] && main_ctrl_reg[MAIN_GLOBAL_EN] |-> irq_low)
        else $error("source one priority wrong");
    a_timer_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        timer_ovf && !timer_ctrl_reg[TCTL_EIGHT_BIT] |-> timer_count == 16'hffff)
        else $error("16-bit overflow at wrong count");
    a_port_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        port_change |=> main_ctrl_reg[MAIN_PORT_FLAG]) else $error("port change lost");
    a_stack_push: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_ack |=> stack_push && stack_push_pc == $past(return_pc)) else $error("return pc not pushed");
    a_shadow_save: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_ack |=> shadow_working == $past(working_register)) else $error("working not shadowed");
endmodule : pirqs_top
`default_nettype wire

// ==== sim/pirqs_core_model.sv ====
// Purpose: core side, takes vectors offered by the source block
// Assumes: one ack per fresh request
// Notes:   a flag left set is not taken twice
`timescale 1ns/100ps
`default_nettype none
module pirqs_core_model (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic irq_high,
    input  wire logic irq_low,
    output logic      irq_ack
);
    logic req_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_reg <= 1'b0;
            irq_ack <= 1'b0;
        end else begin
            req_reg <= irq_high | irq_low;
            irq_ack <= (irq_high | irq_low) & ~req_reg;
        end
    end
endmodule : pirqs_core_model
`default_nettype wire

// ==== sim/pirqs_top_test.sv ====
// Purpose: register-level checks of the source block
// Assumes: axi4-lite master tasks, core model acks vectors
// Notes:   waits bounded; watchdog ends a hang
`timescale 1ns/100ps
`default_nettype none
module pirqs_top_test;
    import pirqs_pkg::*;
    logic aclk=0, aresetn=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0, s_axi_arvalid=0, s_axi_rready=0;
    logic [31:0] s_axi_awaddr=0, s_axi_wdata=0, s_axi_araddr=0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb=4'hf, port_b_pins=4'h0, port_b_is_input=4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic ext_irq_zero=0, ext_irq_one=1, ext_irq_two=0, core_sleeping=0, irq_ack;
    logic [20:0] return_pc=21'h0a5a5, stack_push_pc;
    logic [7:0] working_register=8'h3c, status_register=8'h05, bank_select_register=8'h0b;
    logic [7:0] shadow_working, shadow_status, shadow_bank;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq_high, irq_low, wake_up, stack_push, evt_irq;
    int failures=0, n_tests=0;
    always #50 aclk = ~aclk;
    pirqs_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_irq_zero, .ext_irq_one, .ext_irq_two, .port_b_pins, .port_b_is_input,
        .core_sleeping, .irq_ack, .return_pc, .working_register, .status_register,
        .bank_select_register, .irq_high, .irq_low, .wake_up, .stack_push, .stack_push_pc,
        .shadow_working, .shadow_status, .shadow_bank, .evt_irq);
    pirqs_core_model core (.aclk, .aresetn, .irq_high, .irq_low, .irq_ack);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // ready sampled at the rising edge, valid released there; bready and rready stay high
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, ok;
        int n;
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        ok = 0;
        for (n = 0; n < 100 && !ok; n++) begin
            @(posedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            ok = s_axi_bvalid;
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end
        if (!ok) failures++;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ar_t, ok;
        int n;
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ok = 0;
        for (n = 0; n < 100 && !ok; n++) begin
            @(posedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            ok = s_axi_rvalid;
            rdv = s_axi_rdata;
            rsp = s_axi_rresp;
            if (ar_t) s_axi_arvalid <= 1'b0;
        end
        if (!ok) failures++;
    endtask : rd
    task automatic results();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(100 * 5000);
        failures++;
        results();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADDR_SECOND_CTRL); chk("second", rdv, 32'h70);
        rd(ADDR_THIRD_CTRL);  chk("third", rdv, 32'hc0);
        rd(ADDR_TIMER_CTRL);  chk("tctl", {24'h0, rdv[7:0]}, 32'h40);
        $display("reset test done");
        wr(ADDR_MAIN_CTRL, 32'h90);
        ext_irq_zero <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(ADDR_MAIN_CTRL); chk("main", rdv, 32'h92);
        chk("high", {31'h0, irq_high}, 32'h1);
        chk("pc", {11'h0, stack_push_pc}, 32'h0a5a5);
        chk("shadow", {shadow_working, shadow_status, shadow_bank}, 32'h3c050b);
        wr(ADDR_MAIN_CTRL, 32'h80);
        rd(ADDR_MAIN_CTRL); chk("cleared", rdv, 32'h80);
        chk("off", {31'h0, irq_high}, 32'h0);
        $display("pin0 test done");
        wr(ADDR_SECOND_CTRL, 32'h50);
        wr(ADDR_THIRD_CTRL, 32'h08);
        ext_irq_one <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(ADDR_THIRD_CTRL); chk("third", rdv, 32'h09);
        chk("low", {31'h0, irq_low}, 32'h1);
        wr(ADDR_THIRD_CTRL, 32'h00);
        $display("pin1 test done");
        wr(ADDR_TIMER_CTRL, 32'h0000fec0);
        repeat (4) @(posedge aclk);
        rd(ADDR_MAIN_CTRL); chk("t8", rdv, 32'h84);
        wr(ADDR_TIMER_CTRL, 32'h0000fe80);
        wr(ADDR_MAIN_CTRL, 32'h80);
        repeat (10) @(posedge aclk);
        rd(ADDR_MAIN_CTRL); chk("t16", rdv, 32'h80);
        wr(ADDR_TIMER_CTRL, 32'h00fffe80);
        repeat (4) @(posedge aclk);
        rd(ADDR_MAIN_CTRL); chk("t16wrap", rdv, 32'h84);
        rd(8'h20); chk("resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        $display("timer test done");
        wr(ADDR_EVT_CLEAR, 32'h1f);
        wr(ADDR_EVT_ENABLE, 32'h10);
        wr(ADDR_MAIN_CTRL, 32'h08);
        wr(ADDR_THIRD_CTRL, 32'h10);
        core_sleeping <= 1'b1;
        port_b_pins <= 4'h1;
        ext_irq_two <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(ADDR_MAIN_CTRL); chk("port", rdv, 32'h09);
        rd(ADDR_THIRD_CTRL); chk("pin2", rdv, 32'h12);
        chk("wake", {31'h0, wake_up}, 32'h1);
        chk("nogie", {30'h0, irq_high, irq_low}, 32'h0);
        chk("evirq", {31'h0, evt_irq}, 32'h1);
        rd(ADDR_EVT_STATUS); chk("evst", rdv, 32'h14);
        wr(ADDR_EVT_CLEAR, 32'h14);
        rd(ADDR_EVT_STATUS); chk("evclr", rdv, 32'h0);
        chk("evoff", {31'h0, evt_irq}, 32'h0);
        wr(ADDR_MAIN_CTRL, 32'h89);
        chk("portlow", {31'h0, irq_low}, 32'h1);
        $display("event test done");
        results();
    end
endmodule : pirqs_top_test
`default_nettype wire
